/* File: ctsc_map.svh */
// Register offsets, field positions and reset values of the touch sense control
`ifndef CTSC_MAP_SVH
`define CTSC_MAP_SVH

// ***********************************************
// Register byte offsets
// ***********************************************
`define CTSC_OFS_CTRL_FIRST 8'h00
`define CTSC_OFS_CTRL_SECOND 8'h04
`define CTSC_OFS_TIMER_CFG 8'h08
`define CTSC_ADDR_W 8

// ***********************************************
// sense_control_first fields
// ***********************************************
`define CTSC_F1_ENABLE 7
`define CTSC_F1_REFMODE 6
`define CTSC_F1_RANGE_HI 3
`define CTSC_F1_RANGE_LO 2
`define CTSC_F1_STATUS 1
`define CTSC_F1_T0SEL 0

// ***********************************************
// sense_control_second fields
// ***********************************************
`define CTSC_F2_CH_HI 1
`define CTSC_F2_CH_LO 0

// ***********************************************
// Timer configuration fields
// ***********************************************
`define CTSC_TC_SRC_HI 7
`define CTSC_TC_SRC_LO 6
`define CTSC_TC_T0EXT 4
`define CTSC_TC_GATE_EN 1
`define CTSC_TC_ON 0
`define CTSC_SRC_SENSE 2'h3
`define CTSC_SRC_SYSCLK 2'h1

// ***********************************************
// Reset values and timing
// ***********************************************
`define CTSC_RST_CTRL 8'h00
`define CTSC_INSTR_DIV 2'h3
`define CTSC_HSIZE_WORD 3'h2
`define CTSC_HTRANS_NONSEQ 2'h2

`endif

/* File: ctsc_pkg.sv */
// Types shared by the touch sense control
`default_nettype none

package ctsc_pkg;

    typedef enum logic [2:0] {
        CTSC_RANGE_OFF,
        CTSC_RANGE_NOISE,
        CTSC_RANGE_LOW,
        CTSC_RANGE_MED,
        CTSC_RANGE_HIGH
    } ctsc_range_t;

    typedef struct packed {
        logic osc_on;
        logic pin_drive_on;
        logic ref_low_from_dac;
        logic ref_high_from_fvr;
        ctsc_range_t range;
        logic [3:0] channel_en;
    } ctsc_analog_t;

    typedef struct packed {
        logic first_tick;
        logic second_tick;
    } ctsc_ticks_t;

endpackage : ctsc_pkg

`default_nettype wire

/* File: ctsc_ctrl.sv */
// Digital control of the capacitive touch sense unit with an AHB-Lite slave
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ctsc_map.svh"

module ctsc_ctrl
    import ctsc_pkg::*;
(
    input wire logic clk,                // 50 MHz system clock
    input wire logic rst_n,              // Synchronous reset, active low
    input wire logic hsel,               // Slave select
    input wire logic [31:0] haddr,       // Byte address
    input wire logic [1:0] htrans,       // Transfer type
    input wire logic hwrite,             // Write when high
    input wire logic [2:0] hsize,        // Transfer size
    input wire logic [31:0] hwdata,      // Write data
    input wire logic hready,             // Bus ready in
    output logic [31:0] hrdata,          // Read data
    output logic hreadyout,              // Slave ready
    output logic hresp,                  // Always OKAY
    input wire logic osc_clock_raw,      // Sense oscillator comparator output
    input wire logic osc_status_raw,     // High while sourcing current
    input wire logic first_timer_clock_pin, // External first timer clock pin
    input wire logic second_timer_gate,  // Second timer gate input
    output ctsc_analog_t analog_ctrl,    // Analog oscillator controls
    output ctsc_ticks_t timer_ticks      // Count enables to both timers
);

    // ***********************************************
    // Synchronisers and edge detect
    // ***********************************************
    logic [1:0] osc_clk_sync;
    logic [1:0] osc_stat_sync;
    logic osc_clk_last;
    logic pin_last;
    logic [1:0] next_osc_clk_sync;
    logic [1:0] next_osc_stat_sync;
    logic next_osc_clk_last;
    logic next_pin_last;

    always_comb
    begin
        // First stage feeds only the second stage
        next_osc_clk_sync = {osc_clk_sync[0], osc_clock_raw};
        next_osc_stat_sync = {osc_stat_sync[0], osc_status_raw};
        next_osc_clk_last = osc_clk_sync[1];
        next_pin_last = first_timer_clock_pin;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            osc_clk_sync <= 2'h0;
            osc_stat_sync <= 2'h0;
            osc_clk_last <= 1'b0;
            pin_last <= 1'b0;
        end
        else
        begin
            osc_clk_sync <= next_osc_clk_sync;
            osc_stat_sync <= next_osc_stat_sync;
            osc_clk_last <= next_osc_clk_last;
            pin_last <= next_pin_last;
        end
    end

    logic osc_rise;
    logic pin_rise;
    assign osc_rise = osc_clk_sync[1] & ~osc_clk_last;
    assign pin_rise = first_timer_clock_pin & ~pin_last;

    // ***********************************************
    // Instruction clock divider
    // ***********************************************
    logic [1:0] div_cnt;
    logic [1:0] next_div_cnt;
    logic instr_tick;
    assign instr_tick = (div_cnt == `CTSC_INSTR_DIV);

    always_comb
    begin
        next_div_cnt = div_cnt + 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div_cnt <= 2'h0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
        end
    end

    // ***********************************************
    // AHB-Lite register file
    // ***********************************************
    logic [7:0] ctrl_first;
    logic [1:0] ctrl_second;
    logic [7:0] timer_cfg;
    logic wr_pend;
    logic [`CTSC_ADDR_W-1:0] wr_addr;
    logic [7:0] next_ctrl_first;
    logic [1:0] next_ctrl_second;
    logic [7:0] next_timer_cfg;
    logic next_wr_pend;
    logic [`CTSC_ADDR_W-1:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic addr_phase;

    function automatic logic [31:0] read_word(
        input logic [`CTSC_ADDR_W-1:0] a,
        input logic [7:0] c1,
        input logic [1:0] c2,
        input logic [7:0] tc,
        input logic stat
    );
        logic [7:0] f1;
        f1 = c1;
        // Status bit is not storage, bits 5:4 read zero
        f1[`CTSC_F1_STATUS] = stat;
        f1[5:4] = 2'h0;
        unique case (a)
            `CTSC_OFS_CTRL_FIRST: read_word = {24'h000000, f1};
            `CTSC_OFS_CTRL_SECOND: read_word = {30'h0, c2};
            `CTSC_OFS_TIMER_CFG: read_word = {24'h000000, tc};
            default: read_word = 32'h00000000;
        endcase
    endfunction : read_word

    assign addr_phase = hsel & hready & (htrans == `CTSC_HTRANS_NONSEQ);

    always_comb
    begin
        next_ctrl_first = ctrl_first;
        next_ctrl_second = ctrl_second;
        next_timer_cfg = timer_cfg;
        next_hrdata = hrdata;
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        if (wr_pend)
        begin
            unique case (wr_addr)
                `CTSC_OFS_CTRL_FIRST:
                begin
                    // Status bit is read-only
                    next_ctrl_first = hwdata[7:0] & 8'hcd;
                end
                `CTSC_OFS_CTRL_SECOND:
                begin
                    next_ctrl_second = hwdata[1:0];
                end
                `CTSC_OFS_TIMER_CFG:
                begin
                    next_timer_cfg = hwdata[7:0] & 8'hd3;
                end
                default:
                begin
                    next_ctrl_first = ctrl_first;
                end
            endcase
        end
        if (addr_phase)
        begin
            next_wr_pend = hwrite & (hsize == `CTSC_HSIZE_WORD);
            next_wr_addr = haddr[`CTSC_ADDR_W-1:0];
            if (!hwrite)
            begin
                next_hrdata = read_word(haddr[`CTSC_ADDR_W-1:0], next_ctrl_first, next_ctrl_second,
                                        next_timer_cfg, osc_stat_sync[1]);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_first <= `CTSC_RST_CTRL;
            ctrl_second <= 2'h0;
            timer_cfg <= `CTSC_RST_CTRL;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            ctrl_first <= next_ctrl_first;
            ctrl_second <= next_ctrl_second;
            timer_cfg <= next_timer_cfg;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            // Zero wait states once out of reset
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ***********************************************
    // Analog control decode
    // ***********************************************
    logic unit_on;
    logic ref_var;
    logic [1:0] rng;
    ctsc_analog_t next_analog;
    assign unit_on = ctrl_first[`CTSC_F1_ENABLE];
    assign ref_var = ctrl_first[`CTSC_F1_REFMODE];
    assign rng = ctrl_first[`CTSC_F1_RANGE_HI:`CTSC_F1_RANGE_LO];

    always_comb
    begin
        next_analog.ref_low_from_dac = ref_var;
        next_analog.ref_high_from_fvr = ref_var;
        unique case (rng)
            2'h1: next_analog.range = CTSC_RANGE_LOW;
            2'h2: next_analog.range = CTSC_RANGE_MED;
            2'h3: next_analog.range = CTSC_RANGE_HIGH;
            default: next_analog.range = ref_var ? CTSC_RANGE_NOISE : CTSC_RANGE_OFF;
        endcase
        // Noise mode keeps comparator alive so pin noise still clocks the count
        next_analog.osc_on = unit_on & (ref_var | (rng != 2'h0));
        next_analog.pin_drive_on = next_analog.osc_on & (rng != 2'h0);
        next_analog.channel_en = 4'h0;
        if (unit_on)
        begin
            next_analog.channel_en[ctrl_second] = 1'b1;
        end
    end

    // ***********************************************
    // Timer count enables
    // ***********************************************
    ctsc_ticks_t next_ticks;
    logic [1:0] t2_src;
    logic t2_clk;
    assign t2_src = timer_cfg[`CTSC_TC_SRC_HI:`CTSC_TC_SRC_LO];

    always_comb
    begin
        // Without the external source bit the first timer runs on the instruction clock
        if (timer_cfg[`CTSC_TC_T0EXT])
        begin
            next_ticks.first_tick = ctrl_first[`CTSC_F1_T0SEL] ? osc_rise : pin_rise;
        end
        else
        begin
            next_ticks.first_tick = instr_tick;
        end
        unique case (t2_src)
            `CTSC_SRC_SENSE: t2_clk = osc_rise;
            `CTSC_SRC_SYSCLK: t2_clk = 1'b1;
            default: t2_clk = instr_tick;
        endcase
        next_ticks.second_tick = t2_clk & timer_cfg[`CTSC_TC_ON]
                                 & (~timer_cfg[`CTSC_TC_GATE_EN] | second_timer_gate);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            analog_ctrl <= '0;
            timer_ticks <= '0;
        end
        else
        begin
            analog_ctrl <= next_analog;
            timer_ticks <= next_ticks;
        end
    end

endmodule : ctsc_ctrl

`default_nettype wire

/* File: ctsc_ctrl_properties.sv */
// Concurrent checks on the ports of the touch sense control
`timescale 1ns/1ps
`default_nettype none

module ctsc_ctrl_props
    import ctsc_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write flag
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Slave response
    input wire logic osc_status_raw, // Raw oscillator status
    input wire ctsc_analog_t analog_ctrl, // Analog controls
    input wire ctsc_ticks_t timer_ticks // Count enables
);
    // ***********************************************
    // Port relations
    // ***********************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence rd_first;
        hsel && hready && htrans == 2'h2 && !hwrite && haddr[7:0] == 8'h00;
    endsequence
    sequence held_hi;
        osc_status_raw [*4];
    endsequence
    sequence held_lo;
        !osc_status_raw [*4];
    endsequence

    stat_source_a: assert property ((held_hi ##0 rd_first) |=> hrdata[1])
        else $error("status bit low while sourcing");
    stat_sink_a: assert property ((held_lo ##0 rd_first) |=> !hrdata[1])
        else $error("status bit high while sinking");
    chan_onehot_a: assert property ($onehot0(analog_ctrl.channel_en))
        else $error("more than one channel");
    chan_live_a: assert property (analog_ctrl.osc_on |-> $onehot(analog_ctrl.channel_en))
        else $error("running oscillator without channel");
    ref_pair_a: assert property (analog_ctrl.ref_low_from_dac == analog_ctrl.ref_high_from_fvr)
        else $error("thresholds from mixed sources");
    noise_mode_a: assert property (analog_ctrl.channel_en != 4'h0 && analog_ctrl.range == CTSC_RANGE_NOISE
        |-> analog_ctrl.osc_on && !analog_ctrl.pin_drive_on && analog_ctrl.ref_low_from_dac)
        else $error("noise detection decode wrong");
    range_off_a: assert property (analog_ctrl.channel_en != 4'h0 && analog_ctrl.range == CTSC_RANGE_OFF
        |-> !analog_ctrl.osc_on && !analog_ctrl.ref_low_from_dac)
        else $error("oscillator not off");
    drive_range_a: assert property (analog_ctrl.pin_drive_on |-> analog_ctrl.osc_on
        && analog_ctrl.range inside {CTSC_RANGE_LOW, CTSC_RANGE_MED, CTSC_RANGE_HIGH})
        else $error("pin driven outside a current range");
    reset_clear_a: assert property ($rose(rst_n) |-> analog_ctrl == '0 && timer_ticks == '0)
        else $error("outputs not clear after reset");
    // Status reads rely on a zero-wait, always-okay slave
    bus_okay_a: assert property (!$rose(rst_n) |-> hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
endmodule : ctsc_ctrl_props

bind ctsc_ctrl ctsc_ctrl_props i_props (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_status_raw(osc_status_raw),
    .analog_ctrl(analog_ctrl), .timer_ticks(timer_ticks));

`default_nettype wire

/* File: ctsc_osc_model.sv */
// Behavioural triangle oscillator on the sense pad
`timescale 1ns/1ps
`default_nettype none

module ctsc_osc_model
    import ctsc_pkg::*;
(
    input wire logic clk, // Time base only
    input wire logic [3:0] half, // Half period in clocks
    input wire logic noise, // Noise coupled onto the pad
    input wire ctsc_analog_t analog_ctrl, // Controls from the block
    output logic osc_clock_raw, // Comparator output
    output logic osc_status_raw // High while sourcing
);
    logic [3:0] cnt = 4'h0;
    logic ramp = 1'b0;

    always @(posedge clk)
    begin
        if (!analog_ctrl.osc_on || analog_ctrl.channel_en == 4'h0)
            ramp <= 1'b0;
        else if (!analog_ctrl.pin_drive_on)
            ramp <= noise;
        else if (cnt + 4'h1 >= half)
            ramp <= !ramp;
        cnt <= (cnt + 4'h1 >= half) ? 4'h0 : cnt + 4'h1;
    end

    // Delay keeps the edges away from the sampling clock
    // Pad taken as analog input, so the comparator stalls low only with the oscillator off or no channel enabled
    assign #3 osc_clock_raw = ramp;
    assign #3 osc_status_raw = ramp;
endmodule : ctsc_osc_model

`default_nettype wire

/* File: capacitive_touch_sense_ctrl_tb_top.sv */
// Self-checking bench of the touch sense control
`timescale 1ns/1ps
`default_nettype none

module capacitive_touch_sense_ctrl_tb_top
    import ctsc_pkg::*;
;
    localparam int W = 160;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic osc_clock_raw;
    logic osc_status_raw;
    logic pin = 1'b0;
    logic gate = 1'b0;
    ctsc_analog_t analog_ctrl;
    ctsc_ticks_t timer_ticks;
    ctsc_analog_t e;
    logic [31:0] exp_q[$];
    logic [31:0] rd_m = 32'h0;
    logic rd_dp = 1'b0;
    logic [31:0] seed = 32'h36;
    logic [31:0] r;
    logic [31:0] wm[4] = '{32'hcd, 32'h3, 32'hd3, 32'h0};
    logic en;
    int miscompares = 0;
    int checks = 0;
    int pcnt = 0;

    ctsc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .osc_clock_raw(osc_clock_raw), .osc_status_raw(osc_status_raw),
        .first_timer_clock_pin(pin), .second_timer_gate(gate), .analog_ctrl(analog_ctrl), .timer_ticks(timer_ticks));
    ctsc_osc_model i_osc (.clk(clk), .half(4'h4), .noise(pin), .analog_ctrl(analog_ctrl),
        .osc_clock_raw(osc_clock_raw), .osc_status_raw(osc_status_raw));

    // ***********************************************
    // Clock, pin stimulus and read monitor
    // ***********************************************
    always #10 clk = ~clk;

    always @(posedge clk)
    begin
        pcnt <= (pcnt == 4) ? 0 : pcnt + 1;
        if (pcnt == 4)
            pin <= !pin;
        if (rd_dp && hreadyout)
            chk(hrdata & rd_m, exp_q.pop_front());
        rd_dp <= hsel && hreadyout && htrans == 2'h2 && !hwrite;
        rd_m <= (haddr[7:0] == 8'h00) ? 32'hffff_fffd : 32'hffff_ffff;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Reads carry the expected word, writes the data
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        hsize <= sz;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        if (!w)
            exp_q.push_back(d & ((a == 8'h00) ? 32'hffff_fffd : 32'hffff_ffff));
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
    endtask : bus

    function automatic ctsc_analog_t exp_an(input logic rm, input logic [1:0] rg);
        exp_an.osc_on = rm || rg != 2'h0;
        exp_an.pin_drive_on = rg != 2'h0;
        exp_an.ref_low_from_dac = rm;
        exp_an.ref_high_from_fvr = rm;
        exp_an.range = (rg == 2'h0) ? (rm ? CTSC_RANGE_NOISE : CTSC_RANGE_OFF) : ctsc_range_t'({1'b0, rg} + 3'h1);
        exp_an.channel_en = 4'h1 << rg;
    endfunction : exp_an

    task automatic tk(input logic [7:0] c0, input logic [7:0] tc, input logic g, input int e1, input int e2);
        int a;
        int b;
        a = 0;
        b = 0;
        bus(1'b1, 8'h00, {24'h0, c0}, 3'h2);
        bus(1'b1, 8'h08, {24'h0, tc}, 3'h2);
        gate <= g;
        repeat (8) @(posedge clk);
        // Window from a software loop, never from the timer being clocked
        repeat (W)
        begin
            @(posedge clk);
            #1;
            a += int'(timer_ticks.first_tick === 1'b1);
            b += int'(timer_ticks.second_tick === 1'b1);
        end
        chk(32'(a > e1 - 3 && a < e1 + 3), 32'h1);
        chk(32'(b > e2 - 3 && b < e2 + 3), 32'h1);
    endtask : tk

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++)
            bus(1'b0, 8'(4 * i), 32'h0, 3'h2);
        for (int i = 0; i < 12; i++)
        begin
            r = xs();
            bus(1'b1, 8'(4 * (i % 4)), r, 3'h2);
            bus(1'b0, 8'(4 * (i % 4)), r & wm[i % 4], 3'h2);
        end
        bus(1'b1, 8'h04, 32'h1, 3'h2);
        bus(1'b1, 8'h04, 32'h2, 3'h0);
        bus(1'b0, 8'h04, 32'h1, 3'h2);
        for (int i = 0; i < 9; i++)
        begin
            en = i < 8;
            bus(1'b1, 8'h04, 32'(i % 4), 3'h2);
            bus(1'b1, 8'h00, en ? {24'h0, 1'b1, i[2], 4'(i % 4), 2'h0} : 32'h4c, 3'h2);
            repeat (3) @(posedge clk);
            #1;
            e = exp_an(i[2], 2'(i % 4));
            if (en)
                chk({21'h0, analog_ctrl}, {21'h0, e});
            else
                chk({27'h0, analog_ctrl.osc_on, analog_ctrl.channel_en}, 32'h0);
        end
        tk(8'h8d, 8'hd1, 1'b0, W / 8, W / 8);
        repeat (8)
        begin
            bus(1'b0, 8'h00, 32'h8d, 3'h2);
            @(posedge clk);
        end
        tk(8'h8d, 8'h43, 1'b0, W / 4, 0);
        tk(8'h8d, 8'h43, 1'b1, W / 4, W);
        tk(8'h8d, 8'hd2, 1'b1, W / 8, 0);
        tk(8'h8c, 8'h11, 1'b0, W / 10, W / 4);
        tk(8'hc1, 8'h10, 1'b0, W / 10, 0);
        tk(8'h81, 8'hd1, 1'b0, 0, 0);
        repeat (4) @(posedge clk);
        final_report();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule : capacitive_touch_sense_ctrl_tb_top

`default_nettype wire
